// ===== logic/burst_sram_ports.sv
`timescale 1ns/1ps

`include "sram_ports_map.svh"

module burst_sram_ports
  import sram_ports_pkg::*;
(
  // system
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // link clocks and controls
  input  wire logic                   k,
  input  wire logic                   k_n,
  input  wire logic                   read_port_select_n,
  input  wire logic                   write_port_select_n,
  input  wire logic [`BYTES_PER_WORD-1:0] byte_write_select_n,
  input  wire logic [`ADDR_W-1:0]     addr,
  input  wire logic [`WORD_W-1:0]     d,
  // static straps
  input  wire logic                   pll_disable_n,
  input  wire logic                   impedance_ref_pin,
  // read port
  output logic [`WORD_W-1:0]          q,
  output logic                        q_oe,
  output logic                        read_valid_flag,
  // echo clocks
  output logic                        echo_timing_out,
  output logic                        echo_timing_out_n,
  // impedance control
  output logic                        impedance_update,
  output logic [`ZQ_CODE_W-1:0]       impedance_code
);

  // ****************************************************************
  // storage
  // ****************************************************************
  // burst word 0 lives in the low array, word 1 (address plus one)
  // in the high array at the same row
  word_t     mem_lo [0:`ARRAY_WORDS-1];
  word_t     mem_hi [0:`ARRAY_WORDS-1];

  state_t    s;
  state_t    next_s;
  pins_t     pins_in;
  logic      drain;
  wq_entry_t drain_entry;

  localparam state_t RESET_STATE = '{
    meta:    '0,
    sync:    '0,
    k_prev:  1'b0,
    kn_prev: 1'b0,
    rd0:     '0,
    rd1:     '0,
    rd2:     '0,
    wr:      '0,
    wq:      '0,
    wq_wr:   '0,
    wq_rd:   '0,
    wq_cnt:  '0,
    q:       '0,
    q_oe:    1'b0,
    valid:   1'b0,
    echo:    1'b0,
    echo_n:  1'b0,
    zq_cnt:  '0,
    zq_upd:  1'b0,
    zq_code: `ZQ_CODE_RESET
  };

  // ****************************************************************
  // helpers
  // ****************************************************************
  // overlay new data onto old byte by byte
  function automatic word_t merge(input word_t old_w,
                                  input word_t new_w,
                                  input bsel_t be);
    word_t r;
    r = old_w;
    for (int b = 0; b < `BYTES_PER_WORD; b++)
    begin
      if (be[b])
      begin
        r[b*`BYTE_W +: `BYTE_W] = new_w[b*`BYTE_W +: `BYTE_W];
      end
    end
    return r;
  endfunction

  // newest view of one burst word: array, then queued writes
  // oldest first, then the assembled write still waiting for the queue
  function automatic word_t fetch(input addr_t a, input logic hi);
    word_t                w;
    logic [`WQ_PTR_W-1:0] idx;
    w = hi ? mem_hi[a] : mem_lo[a];
    for (int i = 0; i < `WQ_DEPTH; i++)
    begin
      idx = s.wq_rd + i[`WQ_PTR_W-1:0];
      if ((i < int'(s.wq_cnt)) && (s.wq[idx].addr == a))
      begin
        w = hi ? merge(w, s.wq[idx].d1, s.wq[idx].be1)
               : merge(w, s.wq[idx].d0, s.wq[idx].be0);
      end
    end
    if (s.wr.full && (s.wr.e.addr == a))
    begin
      w = hi ? merge(w, s.wr.e.d1, s.wr.e.be1)
             : merge(w, s.wr.e.d0, s.wr.e.be0);
    end
    return w;
  endfunction

  // ****************************************************************
  // pin bundle
  // ****************************************************************
  assign pins_in = '{
    k:                   k,
    k_n:                 k_n,
    read_port_select_n:  read_port_select_n,
    write_port_select_n: write_port_select_n,
    byte_write_select_n: byte_write_select_n,
    addr:                addr,
    d:                   d,
    pll_disable_n:       pll_disable_n,
    impedance_ref_pin:   impedance_ref_pin
  };

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic  kr;
    logic  knr;
    logic  pll;
    logic  launch;
    logic  lhi;
    addr_t ladr;
    logic  wq_ready;
    logic  push;
    kr       = 1'b0;
    knr      = 1'b0;
    pll      = 1'b0;
    launch   = 1'b0;
    lhi      = 1'b0;
    ladr     = '0;
    wq_ready = 1'b0;
    push     = 1'b0;
    next_s   = s;

    // all pins share one two-stage synchroniser, so k edges and the
    // data they qualify keep their relative skew
    next_s.meta    = pins_in;
    next_s.sync    = s.meta;
    next_s.k_prev  = s.sync.k;
    next_s.kn_prev = s.sync.k_n;
    kr  = s.sync.k & ~s.k_prev;
    knr = s.sync.k_n & ~s.kn_prev;
    pll = s.sync.pll_disable_n;

    // echo clocks run whatever the ports do
    next_s.echo   = s.sync.k;
    next_s.echo_n = s.sync.k_n;

    // read pipeline, advanced on k rises only
    if (kr)
    begin
      if (pll)
      begin
        launch = s.rd2.v;
        ladr   = s.rd2.addr;
        lhi    = 1'b1;
      end
      else
      begin
        launch = s.rd0.v;
        ladr   = s.rd0.addr;
        lhi    = 1'b0;
      end
      next_s.rd2 = s.rd1;
      // pending reads shift whatever the write port does
      next_s.rd1 = s.rd0;
      // select ignored elsewhere; high select is a nop
      next_s.rd0.v    = ~s.sync.read_port_select_n;
      next_s.rd0.addr = s.sync.addr;
      // flag announces the word launched on the next edge
      next_s.valid = pll ? s.rd1.v : s.rd0.v;
    end
    else if (knr)
    begin
      if (pll)
      begin
        launch = s.rd2.v;
        ladr   = s.rd2.addr;
        lhi    = 1'b0;
        next_s.valid = s.rd2.v;
      end
      else
      begin
        launch = s.rd1.v;
        ladr   = s.rd1.addr;
        lhi    = 1'b1;
        next_s.valid = s.rd0.v;
      end
    end

    // output register; a launch edge without a word drops the drive,
    // so the port tristates on that edge even while later reads are pending
    if (kr || knr)
    begin
      next_s.q_oe = launch;
      next_s.q    = launch ? fetch(ladr, lhi) : '0;
    end

    // write assembly; a burst still waiting for the queue blocks a
    // new start, which cannot occur at sane link rates
    if (kr && !s.sync.write_port_select_n && !s.wr.full)
    begin
      next_s.wr.v     = 1'b1;
      next_s.wr.e.d0  = s.sync.d;
      next_s.wr.e.be0 = ~s.sync.byte_write_select_n;
    end
    if (knr && s.wr.v)
    begin
      next_s.wr.v      = 1'b0;
      next_s.wr.full   = 1'b1;
      next_s.wr.e.addr = s.sync.addr;
      next_s.wr.e.d1   = s.sync.d;
      next_s.wr.e.be1  = ~s.sync.byte_write_select_n;
    end

    // write queue: filled from the assembled burst, drained into the
    // arrays; the drain yields to a read launch on the same cycle
    wq_ready = (s.wq_cnt != `WQ_DEPTH);
    push     = s.wr.full & wq_ready;
    drain    = (s.wq_cnt != '0) & ~launch;
    drain_entry = s.wq[s.wq_rd];
    if (push)
    begin
      next_s.wq[s.wq_wr] = s.wr.e;
      next_s.wq_wr       = s.wq_wr + 1'b1;
      next_s.wr.full     = 1'b0;
    end
    if (drain)
    begin
      next_s.wq_rd = s.wq_rd + 1'b1;
    end
    if (push && !drain)
    begin
      next_s.wq_cnt = s.wq_cnt + 1'b1;
    end
    else if (drain && !push)
    begin
      next_s.wq_cnt = s.wq_cnt - 1'b1;
    end

    // periodic impedance step toward the reference comparator
    next_s.zq_upd = 1'b0;
    if (kr)
    begin
      if (s.zq_cnt == `ZQ_PERIOD)
      begin
        next_s.zq_cnt = '0;
        next_s.zq_upd = 1'b1;
        if (s.sync.impedance_ref_pin)
        begin
          if (s.zq_code != `ZQ_CODE_MAX)
          begin
            next_s.zq_code = s.zq_code + 1'b1;
          end
        end
        else if (s.zq_code != `ZQ_CODE_MIN)
        begin
          next_s.zq_code = s.zq_code - 1'b1;
        end
      end
      else
      begin
        next_s.zq_cnt = s.zq_cnt + 1'b1;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s <= RESET_STATE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // array is kept outside the state record; masked bytes stay put
  always_ff @(posedge clock)
  begin
    if (rstn && drain)
    begin
      mem_lo[drain_entry.addr] <= merge(mem_lo[drain_entry.addr],
                                        drain_entry.d0,
                                        drain_entry.be0);
      mem_hi[drain_entry.addr] <= merge(mem_hi[drain_entry.addr],
                                        drain_entry.d1,
                                        drain_entry.be1);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign q                 = s.q;
  assign q_oe              = s.q_oe;
  assign read_valid_flag   = s.valid;
  assign echo_timing_out   = s.echo;
  assign echo_timing_out_n = s.echo_n;
  assign impedance_update  = s.zq_upd;
  assign impedance_code    = s.zq_code;

endmodule

// ===== logic/sram_ports_map.svh
`ifndef SRAM_PORTS_MAP_SVH
`define SRAM_PORTS_MAP_SVH

// ****************************************************************
// array geometry
// ****************************************************************
`define ADDR_W          20
`define WORD_W          18
`define BYTE_W          9
`define BYTES_PER_WORD  2
`define ARRAY_WORDS     (1 << `ADDR_W)

// ****************************************************************
// write queue
// ****************************************************************
`define WQ_DEPTH        2
`define WQ_PTR_W        1
`define WQ_CNT_W        2

// ****************************************************************
// impedance update
// ****************************************************************
`define ZQ_PERIOD       10'd1023
`define ZQ_CNT_W        10
`define ZQ_CODE_W       6
`define ZQ_CODE_RESET   6'h20
`define ZQ_CODE_MAX     6'h3f
`define ZQ_CODE_MIN     6'h00

`endif

// ===== logic/sram_ports_pkg.sv
`include "sram_ports_map.svh"

package sram_ports_pkg;

  typedef logic [`ADDR_W-1:0]         addr_t;
  typedef logic [`WORD_W-1:0]         word_t;
  typedef logic [`BYTES_PER_WORD-1:0] bsel_t;

  // everything the controller drives, sampled together
  typedef struct packed {
    logic  k;
    logic  k_n;
    logic  read_port_select_n;
    logic  write_port_select_n;
    bsel_t byte_write_select_n;
    addr_t addr;
    word_t d;
    logic  pll_disable_n;
    logic  impedance_ref_pin;
  } pins_t;

  typedef struct packed {
    logic  v;
    addr_t addr;
  } rd_req_t;

  typedef struct packed {
    addr_t addr;
    word_t d0;
    word_t d1;
    bsel_t be0;
    bsel_t be1;
  } wq_entry_t;

  typedef struct packed {
    logic      v;
    logic      full;
    wq_entry_t e;
  } wr_stage_t;

  typedef struct packed {
    pins_t                         meta;
    pins_t                         sync;
    logic                          k_prev;
    logic                          kn_prev;
    rd_req_t                       rd0;
    rd_req_t                       rd1;
    rd_req_t                       rd2;
    wr_stage_t                     wr;
    wq_entry_t [`WQ_DEPTH-1:0]     wq;
    logic [`WQ_PTR_W-1:0]          wq_wr;
    logic [`WQ_PTR_W-1:0]          wq_rd;
    logic [`WQ_CNT_W-1:0]          wq_cnt;
    word_t                         q;
    logic                          q_oe;
    logic                          valid;
    logic                          echo;
    logic                          echo_n;
    logic [`ZQ_CNT_W-1:0]          zq_cnt;
    logic                          zq_upd;
    logic [`ZQ_CODE_W-1:0]         zq_code;
  } state_t;

endpackage

// ===== test/sram_ports_asserts.sv
`timescale 1ns/1ps
`include "sram_ports_map.svh"
// ********
// port checks
// ********
module sram_ports_asserts (
  // system
  input wire logic                  clock,
  input wire logic                  rstn,
  // link clocks
  input wire logic                  k,
  input wire logic                  k_n,
  // read port and echo clocks
  input wire logic [`WORD_W-1:0]    q,
  input wire logic                  q_oe,
  input wire logic                  read_valid_flag,
  input wire logic                  echo_timing_out,
  input wire logic                  echo_timing_out_n,
  // impedance
  input wire logic                  impedance_update,
  input wire logic [`ZQ_CODE_W-1:0] impedance_code
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  logic [2:0]  ks;
  logic [10:0] nrise;
  logic        seen;
  logic        krise;

  assign krise = ks[1] & !ks[2];

  // k rises between updates; a fixed sync lag cancels out
  always_ff @(posedge clock)
  begin
    ks <= {ks[1:0], k};
    if (!rstn)
    begin
      nrise <= 11'h0;
      seen <= 1'b0;
    end
    else if (impedance_update)
    begin
      nrise <= {10'h0, krise};
      seen <= 1'b1;
    end
    else
      nrise <= nrise + {10'h0, krise};
  end

  sequence upd_pulse;
    impedance_update ##1 !impedance_update;
  endsequence

  update_pulse_a: assert property (impedance_update |-> upd_pulse)
    else $error("update pulse longer than one clock");
  update_period_a: assert property (impedance_update && seen |-> nrise == 11'h400)
    else $error("update period not 1024 k rises");
  code_gated_a: assert property ($changed(impedance_code) |-> impedance_update || $past(impedance_update))
    else $error("impedance code moved without update");
  code_step_a: assert property ($changed(impedance_code) |-> impedance_code == $past(impedance_code) + 6'h01 || impedance_code == $past(impedance_code) - 6'h01)
    else $error("impedance code step not one");
  reset_idle_a: assert property ($rose(rstn) |-> !q_oe && !read_valid_flag && impedance_code == 6'h20)
    else $error("outputs not idle after reset");
  q_quiet_a: assert property (!q_oe |-> q == '0)
    else $error("read data not quiet while undriven");
  valid_leads_a: assert property ($rose(q_oe) |-> $past(read_valid_flag) && $past(read_valid_flag, 4))
    else $error("valid flag not ahead of data");
  q_holds_a: assert property ($changed(q) && q_oe |=> $stable(q) [*3])
    else $error("read word did not hold");
  echo_rise_a: assert property ($rose(k) |-> ##[2:4] $rose(echo_timing_out))
    else $error("echo clock missed k rise");
  echo_n_rise_a: assert property ($rose(k_n) |-> ##[2:4] $rose(echo_timing_out_n))
    else $error("echo clock missed k_n rise");
endmodule

bind burst_sram_ports sram_ports_asserts u_chk (.clock, .rstn, .k, .k_n,
  .q, .q_oe, .read_valid_flag, .echo_timing_out, .echo_timing_out_n,
  .impedance_update, .impedance_code);

// ===== test/ctrl_model.sv
`timescale 1ns/1ps
// ********
// controller model: free running k, 40 clocks a period
// ********
module ctrl_model
  import sram_ports_pkg::*;
(
  // system
  input  wire logic clock,
  // link
  output logic      k,
  output logic      k_n,
  output logic      read_port_select_n,
  output logic      write_port_select_n,
  output bsel_t     byte_write_select_n,
  output addr_t     addr,
  output word_t     d
);
  int cnt = 0;
  int kcyc = 0;

  initial
  begin
    k = 1'b0;
    k_n = 1'b1;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    byte_write_select_n = 2'h3;
    addr = '0;
    d = '0;
  end

  always @(posedge clock)
  begin
    cnt <= (cnt + 1) % 40;
    kcyc <= kcyc + (cnt == 39);
    k <= (cnt + 1) % 40 < 20;
    k_n <= (cnt + 1) % 40 >= 20;
  end

  task automatic wait_cnt(input int c);
    do @(posedge clock); while (cnt != c);
  endtask

  // 9 clocks setup and 11 hold around each rise
  task automatic op(input logic rd, input logic wr, input addr_t ra,
                    input addr_t wa, input word_t d0, input word_t d1,
                    input bsel_t b0, input bsel_t b1, output int t);
    wait_cnt(30);
    read_port_select_n <= !rd;
    write_port_select_n <= !wr;
    addr <= ra;
    d <= d0;
    byte_write_select_n <= b0;
    t = kcyc + 1;
    wait_cnt(10);
    read_port_select_n <= 1'b1;
    write_port_select_n <= 1'b1;
    addr <= wa;
    d <= d1;
    byte_write_select_n <= b1;
  endtask

  // selects low around a k_n rise only
  task automatic stray;
    wait_cnt(10);
    read_port_select_n <= 1'b0;
    write_port_select_n <= 1'b0;
    addr <= 20'h00001;
    d <= '0;
    wait_cnt(30);
    read_port_select_n <= 1'b1;
    write_port_select_n <= 1'b1;
  endtask
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
`include "sram_ports_map.svh"
module tb;
  import sram_ports_pkg::*;
  logic                  clock = 1'b0;
  logic                  rstn = 1'b0;
  logic                  pll_disable_n = 1'b1;
  logic                  impedance_ref_pin = 1'b1;
  logic                  k;
  logic                  k_n;
  logic                  read_port_select_n;
  logic                  write_port_select_n;
  bsel_t                 byte_write_select_n;
  addr_t                 addr;
  word_t                 d;
  word_t                 q;
  logic                  q_oe;
  logic                  read_valid_flag;
  logic                  echo_timing_out;
  logic                  echo_timing_out_n;
  logic                  impedance_update;
  logic [`ZQ_CODE_W-1:0] impedance_code;
  int                    n_errors = 0;
  int                    n_compared = 0;
  int                    slot;
  logic                  hit;
  logic                  mon = 1'b0;
  word_t                 lo [addr_t];
  word_t                 hi [addr_t];
  int                    slot_q [$];
  word_t                 word_q [$];

  always #2 clock = ~clock;

  burst_sram_ports u_burst_sram_ports (.clock, .rstn, .k, .k_n,
    .read_port_select_n, .write_port_select_n, .byte_write_select_n,
    .addr, .d, .pll_disable_n, .impedance_ref_pin, .q, .q_oe,
    .read_valid_flag, .echo_timing_out, .echo_timing_out_n,
    .impedance_update, .impedance_code);

  ctrl_model u_ctrl (.clock, .k, .k_n, .read_port_select_n,
    .write_port_select_n, .byte_write_select_n, .addr, .d);

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic word_t mrg(word_t o, word_t n, bsel_t b);
    return {b[1] ? o[17:9] : n[17:9], b[0] ? o[8:0] : n[8:0]};
  endfunction

  // ********
  // read port monitor, one look per link half cycle
  // ********
  always @(posedge clock)
    if (mon && (u_ctrl.cnt == 10 || u_ctrl.cnt == 30))
    begin
      slot = 2 * u_ctrl.kcyc + (u_ctrl.cnt == 30);
      hit = slot_q.size() > 0 && slot_q[0] == slot;
      check("q_oe", q_oe, hit);
      check("q", q, hit ? word_q[0] : '0);
      if (hit)
      begin
        void'(slot_q.pop_front());
        void'(word_q.pop_front());
      end
      check("valid", read_valid_flag, slot_q.size() > 0 && slot_q[0] == slot + 1);
    end

  // model applies the write first: newest data wins
  task automatic xfer(input logic rd, input logic wr, input addr_t ra,
                      input addr_t wa, input word_t d0, input word_t d1,
                      input bsel_t b0, input bsel_t b1);
    int t;
    int s;
    u_ctrl.op(rd, wr, ra, wa, d0, d1, b0, b1, t);
    if (wr)
    begin
      lo[wa] = mrg(lo[wa], d0, b0);
      hi[wa] = mrg(hi[wa], d1, b1);
    end
    if (rd)
    begin
      s = pll_disable_n ? 2 * t + 5 : 2 * t + 2;
      slot_q.push_back(s);
      slot_q.push_back(s + 1);
      word_q.push_back(lo[ra]);
      word_q.push_back(hi[ra]);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) xfer(1'b0, 1'b0, ~addr, addr, ~d, d, 2'h0, 2'h0);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_burst;
    xfer(0, 1, 0, 20'h00001, 18'h2aaaa, 18'h15555, 2'h0, 2'h0);
    xfer(0, 1, 0, 20'hfffff, 18'h3ffff, 18'h00000, 2'h0, 2'h0);
    xfer(1, 1, 20'h00001, 20'h00002, 18'h01234, 18'h3cdef, 2'h0, 2'h0);
    xfer(1, 0, 20'hfffff, 0, 0, 0, 2'h3, 2'h3);
    xfer(1, 0, 20'h00002, 0, 0, 0, 2'h3, 2'h3);
    idle(4);
  endtask

  task automatic t_bytes;
    for (int i = 0; i < 4; i++)
    begin
      xfer(0, 1, 0, 20'h00100 + addr_t'(i), 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
      xfer(0, 1, 0, 20'h00100 + addr_t'(i), 18'h0, 18'h0, i[1:0], ~i[1:0]);
    end
    for (int i = 0; i < 4; i++)
      xfer(1, 0, 20'h00100 + addr_t'(i), 0, 0, 0, 2'h3, 2'h3);
    idle(4);
  endtask

  task automatic t_fwd;
    xfer(1, 1, 20'h00002, 20'h00002, 18'h0aaaa, 18'h35555, 2'h0, 2'h0);
    idle(4);
  endtask

  task automatic t_nop;
    u_ctrl.stray();
    idle(2);
    xfer(1, 0, 20'h00001, 0, 0, 0, 2'h3, 2'h3);
    idle(4);
  endtask

  task automatic t_legacy;
    pll_disable_n <= 1'b0;
    idle(2);
    xfer(0, 1, 0, 20'h00200, 18'h11111, 18'h22222, 2'h0, 2'h0);
    xfer(1, 1, 20'h00200, 20'h00201, 18'h33333, 18'h04444, 2'h0, 2'h0);
    xfer(1, 0, 20'h00201, 0, 0, 0, 2'h3, 2'h3);
    idle(4);
    pll_disable_n <= 1'b1;
    idle(2);
  endtask

  task automatic wait_upd;
    int i;
    i = 0;
    while (impedance_update !== 1'b1 && i < 45000)
    begin
      @(posedge clock);
      i++;
    end
    check("update seen", i < 45000, 1'b1);
  endtask

  task automatic t_zq;
    int k0;
    wait_upd();
    k0 = u_ctrl.kcyc;
    repeat (2) @(posedge clock);
    check("code up", impedance_code, 6'h21);
    impedance_ref_pin <= 1'b0;
    wait_upd();
    check("period", u_ctrl.kcyc - k0, 32'h400);
    repeat (2) @(posedge clock);
    check("code down", impedance_code, 6'h20);
  endtask

  initial
  begin
    repeat (95000) @(posedge clock);
    n_errors++;
    print_verdict();
  end

  initial
  begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    check("q_oe", q_oe, 1'b0);
    check("code", impedance_code, 6'h20);
    mon = 1'b1;
    t_burst();
    t_bytes();
    t_fwd();
    t_nop();
    t_legacy();
    t_zq();
    print_verdict();
  end
endmodule
